// [hw/shc_spi_core.v]
// SPI serial port, host or client, with APB register access.
// Assumes one 50 MHz peripheral clock; SPI pins are asynchronous and
// are synchronised here; tristate resolution happens outside.
`timescale 1ns/1ps
`include "shc_spi_defs.vh"

// Functional notes
// [RULE_01] Client select high resets bit counter
// [RULE_02] Select rise mid-byte aborts, data discarded
// [RULE_03] Four clock modes from format field
// [RULE_04] Drive one edge, capture the opposite
// [RULE_05] Host clock offered as level event
// [RULE_06] Port consumes no event inputs
// [RULE_07] Interrupt held while enabled flag set
// [RULE_08] Each source gated by own enable; here both normal sources share enable bit 0
// [RULE_09] Normal sources: transfer done, collision
// [RULE_10] Buffered sources: select, empty, done, receive
// [RULE_11] Order bit: 0 MSB first, 1 LSB
// [RULE_12] Host select: 0 client, 1 host; reset 0
// [RULE_13] Select low in host: fault to client
// [RULE_14] Software rewrites host select after fault
// [RULE_15] Clock double halves host period only
// [RULE_16] Flag register layout depends on buffering
// [RULE_17] Mode codes set idle level and edges
// [RULE_18] Divider codes: 4, 16, 64, 128
// [RULE_19] Done flag cleared by one or read-then-access
// [RULE_20] Busy data write dropped, collision flagged
// [RULE_21] Everything synchronous, documented reset values; reset here is asynchronous
module shc_spi_core (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        sck_in,
	output reg         sck_out,
	output reg         sck_oe,
	input  wire        mosi_in,
	output reg         mosi_out,
	output reg         mosi_oe,
	input  wire        miso_in,
	output reg         miso_out,
	output reg         miso_oe,
	input  wire        ss_b_in,
	output reg         sck_event,
	output reg         irq
);

	// ======================================================================
	// State
	reg [7:0] control_main_ff;
	reg [7:0] control_format_ff;
	reg [7:0] interrupt_enables_ff;
	reg [7:0] sr_ff;
	reg [7:0] txbuf_ff;
	reg [7:0] rxbuf_ff;
	reg       txfull_ff;
	reg       tdone_ff;
	reg       write_collision_flag_ff;
	reg       rxc_ff;
	reg       txc_ff;
	reg       ssi_ff;
	reg       ovf_ff;
	reg       armed_ff;
	reg       busy_ff;
	reg [7:0] tmr_ff;
	reg [4:0] edge_cnt_ff;
	reg [3:0] bit_cnt_ff;
	reg       sck_prev_ff;
	reg       ss_prev_ff;
	reg [7:0] rcv_ff;
	reg [1:0] hsmp_ff;
	reg       evt_held_ff;

	wire [3:0] pins_s;
	wire       s_sck;
	wire       s_mosi;
	wire       s_miso;
	wire       s_ss_b;

	// Pin inputs cross into the clock domain; select idles high
	shc_sync #(
		.W    (4),
		.INIT (4'h8)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.d     ({ss_b_in, miso_in, mosi_in, sck_in}),
		.q     (pins_s)
	);
	assign s_sck  = pins_s[0];
	assign s_mosi = pins_s[1];
	assign s_miso = pins_s[2];
	assign s_ss_b = pins_s[3];

	// ======================================================================
	// Bus decode
	wire       apb_setup = psel & ~penable;
	wire       apb_done  = psel & penable & pready;
	wire [2:0] idx       = paddr[4:2];
	wire       hit       = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0) && (idx <= `SHC_IDX_SHIFT_DATA);
	wire       wr        = apb_done & pwrite & hit;
	wire       rd        = apb_done & ~pwrite & hit;
	wire       wr_cm     = wr & (idx == `SHC_IDX_CONTROL_MAIN);
	wire       wr_flag   = wr & (idx == `SHC_IDX_FLAG_BANK);
	wire       rd_flag   = rd & (idx == `SHC_IDX_FLAG_BANK);
	wire       wr_data   = wr & (idx == `SHC_IDX_SHIFT_DATA);
	wire       rd_data   = rd & (idx == `SHC_IDX_SHIFT_DATA);
	wire       acc_data  = wr_data | rd_data;

	// ======================================================================
	// Configuration fields
	wire       enable  = control_main_ff[`SHC_CM_ENABLE];
	wire       host    = control_main_ff[`SHC_CM_HOST];
	wire       order   = control_main_ff[`SHC_CM_ORDER];
	wire       dbl     = control_main_ff[`SHC_CM_DOUBLE];
	wire [1:0] div_sel = control_main_ff[`SHC_CM_DIV_HI:`SHC_CM_DIV_LO];
	wire       buffered_mode_enable   = control_format_ff[`SHC_CF_BUFFERED_MODE_ENABLE];
	wire       buffered_wait_receive   = control_format_ff[`SHC_CF_BUFFERED_WAIT_RECEIVE];
	wire       select_line_disable     = control_format_ff[`SHC_CF_SSD];
	wire       cpol    = control_format_ff[`SHC_CF_MODE_HI]; // RULE_03
	wire       cpha    = control_format_ff[`SHC_CF_MODE_LO]; // RULE_03

	// Undoubled period of host clock in peripheral clocks; half_per below is half of it, or a quarter when doubled
	reg  [7:0] div_ratio;
	always @*
	begin
		case (div_sel)
			2'h0:    div_ratio = `SHC_DIV_CODE0; // RULE_18
			2'h1:    div_ratio = `SHC_DIV_CODE1;
			2'h2:    div_ratio = `SHC_DIV_CODE2;
			default: div_ratio = `SHC_DIV_CODE3;
		endcase
	end
	// Doubling only matters here, so client timing never sees it
	wire [7:0] half_per = dbl ? (div_ratio >> 2) : (div_ratio >> 1); // RULE_15

	// ======================================================================
	// Edge events, shared by host and client
	wire host_on   = enable & host;
	wire sel       = enable & ~host & ~s_ss_b;
	wire tick      = busy_ff & (tmr_ff == (half_per - 8'h01));
	wire rise      = s_sck & ~sck_prev_ff;
	wire fall      = ~s_sck & sck_prev_ff;
	wire lead      = host_on ? (tick & (sck_out == cpol)) : (sel & (cpol ? fall : rise)); // RULE_17
	wire trail     = host_on ? (tick & (sck_out != cpol)) : (sel & (cpol ? rise : fall)); // RULE_17
	wire sample_ev = cpha ? trail : lead; // RULE_04
	wire setup_ev  = cpha ? lead : trail; // RULE_04
	wire rx_bit    = host_on ? s_miso : s_mosi;
	wire out_bit   = order ? sr_ff[0] : sr_ff[7]; // RULE_11
	wire [7:0] sr_shift = order ? {rx_bit, sr_ff[7:1]} : {sr_ff[6:0], rx_bit}; // RULE_11
	wire [7:0] rcv_shift = order ? {rx_bit, rcv_ff[7:1]} : {rcv_ff[6:0], rx_bit}; // RULE_11
	wire byte_end  = host_on ? (tick & (edge_cnt_ff == `SHC_HOST_EDGES))
	                         : (sample_ev & (bit_cnt_ff == `SHC_LAST_BIT));
	wire [7:0] rx_byte = sample_ev ? sr_shift : sr_ff;
	wire busy_any  = host_on ? busy_ff : (sel & (bit_cnt_ff != 4'h0));
	wire fault     = host_on & ~select_line_disable & ~s_ss_b; // RULE_13

	// ======================================================================
	// Loading the shift register from software or the transmit buffer
	reg       load;
	reg [7:0] load_val;
	reg       start;
	reg       buf_take;
	reg       buf_put;
	always @*
	begin
		load     = 1'b0;
		load_val = txbuf_ff;
		start    = 1'b0;
		buf_take = 1'b0;
		buf_put  = 1'b0;
		if (wr_data && !buffered_mode_enable && !busy_any)
		begin
			load     = 1'b1;
			load_val = pwdata[7:0];
			start    = host_on;
		end
		else if (wr_data && buffered_mode_enable && !txfull_ff && buffered_wait_receive && !busy_any && (host_on || s_ss_b))
		begin
			load     = 1'b1;
			load_val = pwdata[7:0];
			start    = host_on;
		end
		else if (wr_data && buffered_mode_enable && !txfull_ff)
			buf_put = 1'b1;
		// Buffered data moves on at a byte end, or when the host is idle
		if (buffered_mode_enable && txfull_ff && (byte_end || (host_on && !busy_ff)))
		begin
			load     = 1'b1;
			load_val = txbuf_ff;
			start    = host_on;
			buf_take = 1'b1;
		end
	end

	// ======================================================================
	// Registers written by software; a mode fault overrides a host write
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			control_main_ff      <= `SHC_RST_CONTROL_MAIN; // RULE_21
			control_format_ff    <= `SHC_RST_CONTROL_FORMAT;
			interrupt_enables_ff <= `SHC_RST_IRQ_ENABLES;
		end
		else
		begin
			if (fault)
				control_main_ff <= (wr_cm ? pwdata[7:0] : control_main_ff) & `SHC_CM_MASK &
				                   ~(8'h01 << `SHC_CM_HOST); // RULE_13 RULE_14
			else if (wr_cm)
				control_main_ff <= pwdata[7:0] & `SHC_CM_MASK; // RULE_12
			if (wr && idx == `SHC_IDX_CONTROL_FORMAT)
				control_format_ff <= pwdata[7:0] & `SHC_CF_MASK;
			if (wr && idx == `SHC_IDX_IRQ_ENABLES)
				interrupt_enables_ff <= pwdata[7:0] & `SHC_IE_MASK; // RULE_08
		end
	end

	// ======================================================================
	// Serial engine: host clock timer, counters and shift register
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_ff     <= 1'b0;
			tmr_ff      <= 8'h00;
			edge_cnt_ff <= 5'h00;
			bit_cnt_ff  <= 4'h0;
			sr_ff       <= `SHC_RST_SHIFT_DATA;
			sck_out     <= 1'b0;
			sck_prev_ff <= 1'b0;
			ss_prev_ff  <= 1'b1;
			rcv_ff      <= 8'h00;
			hsmp_ff     <= 2'h0;
		end
		else
		begin
			sck_prev_ff <= s_sck;
			ss_prev_ff  <= s_ss_b;
			if (!host_on || fault)
			begin
				// Leaving host mode drops any host frame at once
				busy_ff     <= 1'b0;
				tmr_ff      <= 8'h00;
				edge_cnt_ff <= 5'h00;
				sck_out     <= cpol; // RULE_17
			end
			else if (tick)
			begin
				tmr_ff      <= 8'h00;
				sck_out     <= ~sck_out;
				edge_cnt_ff <= edge_cnt_ff + 5'h01;
				if (byte_end)
				begin
					busy_ff     <= start;
					edge_cnt_ff <= 5'h00;
				end
			end
			else if (busy_ff)
				tmr_ff <= tmr_ff + 8'h01;
			else
			begin
				busy_ff <= start;
				sck_out <= cpol;
			end
			// Client framing restarts on every select low period
			if (!sel)
				bit_cnt_ff <= 4'h0; // RULE_01 RULE_02
			else if (sample_ev)
				bit_cnt_ff <= byte_end ? 4'h0 : bit_cnt_ff + 4'h1;
			if (load)
				sr_ff <= load_val;
			else if (sample_ev)
				sr_ff <= sr_shift; // RULE_04
			// Synced miso trails the host clock by two cycles, so the host
			// takes its bit two cycles after its own sample edge
			hsmp_ff <= {hsmp_ff[0], host_on & sample_ev};
			if (host_on ? hsmp_ff[1] : sample_ev)
				rcv_ff <= rcv_shift; // RULE_04
		end
	end

	// ======================================================================
	// Pin drivers; data changes only on setup edges, loads or while idle, so the far end's
	// capture edge always sees a settled bit
	wire idle_line = host_on ? ~busy_ff : ~sel;
	wire nxt_dout  = load ? (order ? load_val[0] : load_val[7]) : out_bit;
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mosi_out  <= 1'b0;
			miso_out  <= 1'b0;
			sck_oe    <= 1'b0;
			mosi_oe   <= 1'b0;
			miso_oe   <= 1'b0;
			sck_event <= 1'b0;
			evt_held_ff <= 1'b0;
		end
		else
		begin
			if (load || setup_ev || idle_line)
			begin
				mosi_out <= nxt_dout; // RULE_04
				miso_out <= nxt_dout; // RULE_04
			end
			sck_oe    <= host_on & ~fault;
			mosi_oe   <= host_on & ~fault;
			miso_oe   <= sel; // RULE_02
			// Level follows the host clock but stands two clocks at least,
			// so a doubled fastest clock is smoothed rather than passed on
			if (((host_on & sck_out) != sck_event) && evt_held_ff)
			begin
				sck_event   <= host_on & sck_out; // RULE_05 RULE_06
				evt_held_ff <= 1'b0;
			end
			else
				evt_held_ff <= 1'b1; // RULE_05
		end
	end

	// ======================================================================
	// Buffers and flags; a hardware set always wins over a clear
	wire clr_tdone = (wr_flag & pwdata[`SHC_FN_TDONE]) | (acc_data & armed_ff); // RULE_19
	wire clr_write_collision_flag = acc_data & armed_ff;
	wire set_tdone = (byte_end & ~buffered_mode_enable) | fault; // RULE_13
	wire set_write_collision_flag = wr_data & ~buffered_mode_enable & busy_any; // RULE_20
	wire set_rxc   = byte_end & buffered_mode_enable;
	wire clr_rxc   = (rd_data & buffered_mode_enable) | (wr_flag & buffered_mode_enable & pwdata[`SHC_FB_RXC]);
	wire set_txc   = byte_end & buffered_mode_enable & ~txfull_ff;
	wire set_ssi   = buffered_mode_enable & enable & ~host & ~s_ss_b & ss_prev_ff;
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tdone_ff  <= 1'b0;
			write_collision_flag_ff  <= 1'b0;
			rxc_ff    <= 1'b0;
			txc_ff    <= 1'b0;
			ssi_ff    <= 1'b0;
			ovf_ff    <= 1'b0;
			armed_ff  <= 1'b0;
			txfull_ff <= 1'b0;
			txbuf_ff  <= 8'h00;
			rxbuf_ff  <= 8'h00;
		end
		else
		begin
			tdone_ff <= set_tdone | (tdone_ff & ~clr_tdone); // RULE_19
			write_collision_flag_ff <= set_write_collision_flag | (write_collision_flag_ff & ~clr_write_collision_flag); // RULE_20
			rxc_ff   <= set_rxc | (rxc_ff & ~clr_rxc);
			txc_ff   <= set_txc | (txc_ff & ~(wr_flag & pwdata[`SHC_FB_TXC]));
			ssi_ff   <= set_ssi | (ssi_ff & ~(wr_flag & pwdata[`SHC_FB_SSI]));
			ovf_ff   <= (set_rxc & rxc_ff & ~clr_rxc) | (ovf_ff & ~(wr_flag & pwdata[`SHC_FB_OVF]));
			// Armed by a flag read that saw a flag set, used by the next data access
			if (acc_data)
				armed_ff <= 1'b0;
			else if (rd_flag && !buffered_mode_enable && (prdata[`SHC_FN_TDONE] || prdata[`SHC_FN_WRITE_COLLISION_FLAG]))
				armed_ff <= 1'b1;
			if (set_rxc)
				rxbuf_ff <= rx_byte;
			if (buf_put)
			begin
				txbuf_ff  <= pwdata[7:0];
				txfull_ff <= 1'b1;
			end
			else if (buf_take || !buffered_mode_enable)
				txfull_ff <= 1'b0;
		end
	end

	// ======================================================================
	// Single interrupt line from enabled flags
	wire [3:0] buf_src = {rxc_ff, txc_ff, ~txfull_ff, ssi_ff}; // RULE_10
	wire nxt_irq = buffered_mode_enable ? |(buf_src & interrupt_enables_ff[`SHC_IE_RXC:`SHC_IE_SSI]) // RULE_08
	                     : interrupt_enables_ff[`SHC_IE_NORM] & (tdone_ff | write_collision_flag_ff); // RULE_09
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= enable & nxt_irq; // RULE_07
	end

	// ======================================================================
	// APB slave: read data captured in setup, ready in the second access cycle
	reg [7:0] rd_val;
	always @*
	begin
		case (idx)
			`SHC_IDX_CONTROL_MAIN:   rd_val = control_main_ff;
			`SHC_IDX_CONTROL_FORMAT: rd_val = control_format_ff;
			`SHC_IDX_IRQ_ENABLES:    rd_val = interrupt_enables_ff;
			`SHC_IDX_FLAG_BANK:      rd_val = buffered_mode_enable ? {rxc_ff, txc_ff, ~txfull_ff, ssi_ff, 3'h0, ovf_ff}
			                                        : {tdone_ff, write_collision_flag_ff, 6'h00}; // RULE_16
			`SHC_IDX_SHIFT_DATA:     rd_val = buffered_mode_enable ? rxbuf_ff : rcv_ff;
			default:                 rd_val = 8'h00;
		endcase
	end
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			if (apb_setup && !pwrite)
				prdata <= hit ? {24'h000000, rd_val} : 32'h00000000;
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
		end
	end

endmodule

// [hw/shc_spi_defs.vh]
// Constants of the SPI host/client core: register word indexes, field
// positions, reset values and clock divider figures.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef SHC_SPI_DEFS_VH
`define SHC_SPI_DEFS_VH

// ==========================================================================
// Register indexes (byte address is four times the index)
`define SHC_IDX_CONTROL_MAIN   3'h0
`define SHC_IDX_CONTROL_FORMAT 3'h1
`define SHC_IDX_IRQ_ENABLES    3'h2
`define SHC_IDX_FLAG_BANK      3'h3
`define SHC_IDX_SHIFT_DATA     3'h4

// ==========================================================================
// control_main fields
`define SHC_CM_ORDER   6
`define SHC_CM_HOST    5
`define SHC_CM_DOUBLE  4
`define SHC_CM_DIV_HI  2
`define SHC_CM_DIV_LO  1
`define SHC_CM_ENABLE  0
`define SHC_CM_MASK    8'h77

// control_format fields
`define SHC_CF_BUFFERED_MODE_ENABLE   7
`define SHC_CF_BUFFERED_WAIT_RECEIVE   6
`define SHC_CF_SSD     2
`define SHC_CF_MODE_HI 1
`define SHC_CF_MODE_LO 0
`define SHC_CF_MASK    8'hC7

// interrupt_enables fields
`define SHC_IE_RXC     7
`define SHC_IE_TXC     6
`define SHC_IE_DRE     5
`define SHC_IE_SSI     4
`define SHC_IE_NORM    0
`define SHC_IE_MASK    8'hF1

// interrupt_flag_bank fields (normal and buffered layouts)
`define SHC_FN_TDONE   7
`define SHC_FN_WRITE_COLLISION_FLAG   6
`define SHC_FB_RXC     7
`define SHC_FB_TXC     6
`define SHC_FB_DRE     5
`define SHC_FB_SSI     4
`define SHC_FB_OVF     0

// ==========================================================================
// Reset values
`define SHC_RST_CONTROL_MAIN   8'h00
`define SHC_RST_CONTROL_FORMAT 8'h00
`define SHC_RST_IRQ_ENABLES    8'h00
`define SHC_RST_SHIFT_DATA     8'h00

// ==========================================================================
// Timing: peripheral clock divide ratios and frame length
`define SHC_DIV_CODE0  8'h04
`define SHC_DIV_CODE1  8'h10
`define SHC_DIV_CODE2  8'h40
`define SHC_DIV_CODE3  8'h80
`define SHC_HOST_EDGES 5'h0F
`define SHC_LAST_BIT   4'h7

`endif

// [hw/shc_sync.v]
// Two-flop synchroniser bank for the SPI pin inputs.
// Assumes asynchronous pins; reset values given per bit by INIT.
`timescale 1ns/1ps

module shc_sync #(
	parameter       W    = 4,
	parameter [3:0] INIT = 4'h0
) (
	input  wire         clock,
	input  wire         rst_b,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	// ======================================================================
	// One two-stage chain per bit
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			reg meta_ff;
			reg sync_ff;
			// First stage feeds only the second stage
			always @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					meta_ff <= INIT[i];
					sync_ff <= INIT[i];
				end
				else
				begin
					meta_ff <= d[i];
					sync_ff <= meta_ff;
				end
			end
			assign q[i] = sync_ff;
		end
	endgenerate

endmodule

// [sim/shc_spi_core_monitor.sv]
// Checker on the SPI core ports: APB answer, map, event, irq mask, select.
// Assumes a fixed two-cycle APB answer and two-flop pin synchronisers.
`timescale 1ns/1ps

// ====================
// Port checker
module shc_spi_core_monitor (
	input logic        clock,
	input logic        rst_b,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        sck_out,
	input logic        sck_oe,
	input logic        mosi_oe,
	input logic        miso_oe,
	input logic        ss_b_in,
	input logic        sck_event,
	input logic        irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// Completed access, and addresses outside the five-word map
	wire acc_done = psel && penable && pready;
	wire unmapped = (paddr[4:2] > 3'h4) || (paddr[1:0] != 2'h0) || (paddr[7:5] != 3'h0);

	// Steps of an access, and the write that masks every source
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	sequence s_mask_all;
		acc_done && pwrite && paddr == 8'h08 && pwdata[7:0] == 8'h00;
	endsequence

	property p_answer;
		s_access |=> s_answer;
	endproperty
	a_answer: assert property (p_answer) else $error("pready not in second access cycle");
	property p_map;
		acc_done |-> pslverr == unmapped;
	endproperty
	a_map: assert property (p_map) else $error("pslverr disagrees with map");
	property p_pad;
		acc_done && !pwrite |-> prdata[31:8] == 24'h000000 && (!pslverr || prdata == 32'h0);
	endproperty
	a_pad: assert property (p_pad) else $error("read data not padded");
	// Event copy has caught up with a host clock level that stood two samples
	property p_event;
		sck_oe [*2] ##0 $stable(sck_out) |=> sck_event == $past(sck_out);
	endproperty
	a_event: assert property (p_event) else $error("event does not follow host clock");
	// Every event level stands two clocks at least
	property p_event_hold;
		$changed(sck_event) |=> $stable(sck_event);
	endproperty
	a_event_hold: assert property (p_event_hold) else $error("event level shorter than two clocks");
	property p_mask;
		s_mask_all |-> ##[1:2] !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq with all sources masked");
	// Select held low must knock the port out of host mode
	property p_fault;
		!ss_b_in [*6] |-> !sck_oe;
	endproperty
	a_fault: assert property (p_fault) else $error("host drive kept under low select");
	property p_roles;
		mosi_oe == sck_oe && !(miso_oe && sck_oe);
	endproperty
	a_roles: assert property (p_roles) else $error("drivers of both roles on");
	property p_release;
		$rose(ss_b_in) |-> ##[1:4] !miso_oe;
	endproperty
	a_release: assert property (p_release) else $error("miso kept after deselect");
endmodule

bind shc_spi_core shc_spi_core_monitor u_shc_spi_core_monitor (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sck_out(sck_out), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
	.ss_b_in(ss_b_in), .sck_event(sck_event), .irq(irq)
);

// [sim/shc_spi_client_model.sv]
// Far-side SPI client: shifts tx out MSB first, collects rx from mosi.
// Assumes the bench drives select and mode; behavioural, on sck edges.
`timescale 1ns/1ps

// ====================
// Client model
module shc_spi_client_model (
	input  wire       sck,
	input  wire       mosi,
	input  wire       cs_b,
	input  wire [1:0] mode,
	input  wire [7:0] tx,
	output reg        miso,
	output reg  [7:0] rx
);
	integer ns = 0;
	// Modes 0 and 3 sample on the rising edge, 1 and 2 on the falling one
	wire smp_rise = (mode[0] == mode[1]);

	// A fresh select restarts the byte
	always @(negedge cs_b)
	begin
		ns = 0;
		rx = 8'h00;
	end
	// Capture on the sample edge, advance the output on the other
	always @(posedge sck)
	begin
		if (!cs_b && smp_rise)
			rx = {rx[6:0], mosi};
		else if (!cs_b)
			ns = ns + 1;
	end
	always @(negedge sck)
	begin
		if (!cs_b && !smp_rise)
			rx = {rx[6:0], mosi};
		else if (!cs_b)
			ns = ns + 1;
	end
	// Outside the byte the line shows no held value, so stale reads fail
	always @*
		miso = (cs_b || ns < mode[0] || ns > mode[0] + 7) ? ~rx[0] : tx[7 - (ns - mode[0])];
endmodule

// [sim/shc_spi_core_test.sv]
// Bench for the SPI core: APB tasks, client model on the far side.
// Assumes the core answers APB in the second access cycle.
`timescale 1ns/1ps

// ====================
// Bench top
module shc_spi_core_test;
	reg         clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	reg         sck_drv = 1'b0, mosi_drv = 1'b0, ss_b = 1'b1, pcs_b = 1'b1, sck_prev = 1'b0;
	reg  [7:0]  paddr = 8'h00, ptx = 8'h00;
	reg  [1:0]  pmode = 2'h0;
	reg  [31:0] pwdata = 32'h0, rd;
	integer     n_mismatch = 0, num_checks = 0, run = 0, gap = 0, i;
	wire [31:0] prdata;
	wire [7:0]  prx;
	wire        pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sck_event, irq, pmiso;
	// Whoever enables a pin drives the wire
	wire        sck_w = sck_oe ? sck_out : sck_drv;
	wire        mosi_w = mosi_oe ? mosi_out : mosi_drv;
	wire        miso_w = miso_oe ? miso_out : pmiso;

	shc_spi_core u_shc_spi_core (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
		.ss_b_in(ss_b), .sck_event(sck_event), .irq(irq)
	);
	shc_spi_client_model u_shc_spi_client_model (
		.sck(sck_w), .mosi(mosi_w), .cs_b(pcs_b), .mode(pmode), .tx(ptx), .miso(pmiso), .rx(prx)
	);

	initial
	begin
		forever #10 clock = ~clock;
	end
	// Cycles between host clock changes; the last gap is a half period
	always @(posedge clock)
	begin
		run <= (sck_out !== sck_prev) ? 1 : run + 1;
		if (sck_out !== sck_prev)
			gap <= run;
		sck_prev <= sck_out;
	end

	// ====================
	// Shared tasks
	task chk(input [31:0] got, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task report_and_stop;
	begin
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	task give_up;
	begin
		chk(32'h0, 32'h1);
		report_and_stop;
	end
	endtask
	// One APB transfer; request held until pready is seen high
	task apb(input w, input [7:0] a, input [7:0] d);
		integer k;
	begin
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		for (k = 0; k < 16 && pready !== 1'b1; k = k + 1)
			@(posedge clock);
		if (pready !== 1'b1)
			give_up;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	end
	endtask
	task wait_done;
		integer k;
	begin
		rd = 32'h0;
		for (k = 0; k < 600 && rd[7] !== 1'b1; k = k + 1)
			apb(1'b0, 8'h0C, 8'h00);
		if (rd[7] !== 1'b1)
			give_up;
	end
	endtask
	function [7:0] rev(input [7:0] v);
		integer k;
	begin
		for (k = 0; k < 8; k = k + 1)
			rev[k] = v[7 - k];
	end
	endfunction
	// Half period in clocks: divide by 4, 16, 64, 128, halved when doubled
	function integer half(input [7:0] cm);
	begin
		half = (cm[2:1] == 2'h3) ? 64 : 2 << (2 * cm[2:1]);
		if (cm[4])
			half = half / 2;
	end
	endfunction

	// ====================
	// Scenarios
	task reset_values;
		reg [7:0] a;
	begin
		for (a = 8'h00; a < 8'h14; a = a + 8'h04)
		begin
			apb(1'b0, a, 8'h00);
			chk(rd, 32'h0);
		end
		apb(1'b0, 8'h14, 8'h00);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 8'h00, 8'hFF);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h77);
		apb(1'b1, 8'h00, 8'h00);
	end
	endtask
	// Host byte against the model; a collision write is dropped when asked
	task host_frame(input [7:0] cm, input [1:0] md, input [7:0] tx, input coll);
	begin
		apb(1'b1, 8'h04, {6'h0, md});
		apb(1'b1, 8'h00, cm);
		pmode <= md;
		ptx <= ~tx;
		pcs_b <= 1'b0;
		apb(1'b1, 8'h10, tx);
		if (coll)
			apb(1'b1, 8'h10, ~tx);
		wait_done;
		chk(rd, coll ? 32'hC0 : 32'h80);
		chk({31'h0, irq}, {31'h0, coll});
		apb(1'b0, 8'h10, 8'h00);
		chk(rd, {24'h0, cm[6] ? rev(~tx) : ~tx});
		chk({24'h0, prx}, {24'h0, cm[6] ? rev(tx) : tx});
		chk(gap, half(cm));
		chk({31'h0, sck_out}, {31'h0, md[1]});
		pcs_b <= 1'b1;
		apb(1'b0, 8'h0C, 8'h00);
		chk(rd, 32'h0);
		chk({31'h0, irq}, 32'h0);
	end
	endtask
	task mode_fault;
	begin
		apb(1'b1, 8'h04, 8'h00);
		apb(1'b1, 8'h00, 8'h21);
		ss_b <= 1'b0;
		repeat (8) @(posedge clock);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h01);
		apb(1'b0, 8'h0C, 8'h00);
		chk(rd, 32'h80);
		ss_b <= 1'b1;
		apb(1'b1, 8'h0C, 8'h80);
		apb(1'b0, 8'h0C, 8'h00);
		chk(rd, 32'h0);
		apb(1'b1, 8'h00, 8'h21);
		apb(1'b0, 8'h00, 8'h00);
		chk(rd, 32'h21);
	end
	endtask
	// Bench as host in mode 0; half period of four clocks
	task send_bits(input [7:0] v, input integer n);
		integer k;
	begin
		for (k = 0; k < n; k = k + 1)
		begin
			mosi_drv <= v[7 - k];
			repeat (4) @(posedge clock);
			sck_drv <= 1'b1;
			repeat (4) @(posedge clock);
			sck_drv <= 1'b0;
		end
		repeat (4) @(posedge clock);
	end
	endtask
	// Half a byte, deselect, then a whole byte must land intact
	task client_abort;
	begin
		apb(1'b1, 8'h00, 8'h01);
		ss_b <= 1'b0;
		send_bits(8'hF0, 4);
		ss_b <= 1'b1;
		repeat (8) @(posedge clock);
		ss_b <= 1'b0;
		send_bits(8'h5A, 8);
		ss_b <= 1'b1;
		repeat (8) @(posedge clock);
		apb(1'b0, 8'h0C, 8'h00);
		chk(rd, 32'h80);
		apb(1'b0, 8'h10, 8'h00);
		chk(rd, 32'h5A);
	end
	endtask
	task buffered_flags;
	begin
		apb(1'b1, 8'h04, 8'h80);
		apb(1'b0, 8'h0C, 8'h00);
		chk(rd, 32'h20);
		apb(1'b1, 8'h08, 8'h20);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h08, 8'h00);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
	end
	endtask

	// ====================
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		reset_values;
		for (i = 0; i < 8; i = i + 1)
			host_frame(8'h21 | {1'b0, i[0] ^ i[2], 1'b0, i[2], 1'b0, i[1:0], 1'b0}, i[1:0], 8'h96 + i[7:0], 1'b0);
		apb(1'b1, 8'h08, 8'h01);
		host_frame(8'h27, 2'h1, 8'hC3, 1'b1);
		apb(1'b1, 8'h08, 8'h00);
		mode_fault;
		client_abort;
		buffered_flags;
		report_and_stop;
	end
endmodule
